// ==== hw/ucebd_pkg.sv ====
package ucebd_pkg;

  // sfr addresses
  localparam logic [7:0] ADDR_SERIAL_CONTROL_REG   = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_DATA_BUFFER   = 8'h99;
  localparam logic [7:0] ADDR_BAUD_ERROR_CONTROL_REG = 8'h9E;

  // serial_control_reg fields
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_SM2     = 5;
  localparam int SC_REN     = 4;
  localparam int SC_TB8     = 3;
  localparam int SC_RB8     = 2;
  localparam int SC_TI      = 1;
  localparam int SC_RI      = 0;

  // baud_error_control_reg fields
  localparam int BE_OWE     = 7;
  localparam int BE_FE      = 6;
  localparam int BE_BRK     = 5;
  localparam int BE_SBTH_HI = 4;
  localparam int BE_SBTH_LO = 3;
  localparam int BE_DIV_HI  = 2;
  localparam int BE_DIV_LO  = 0;

  // reset values
  localparam logic [7:0] SERIAL_CONTROL_REG_RST   = 8'h00;
  localparam logic [7:0] SERIAL_DATA_BUFFER_RST   = 8'h00;
  localparam logic [7:0] BAUD_ERROR_CONTROL_REG_RST = 8'h00;

  // serial_mode_select encodings
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8VAR  = 2'h1;
  localparam logic [1:0] MODE_9FIX  = 2'h2;
  localparam logic [1:0] MODE_9VAR  = 2'h3;

  // timing counts
  localparam logic [3:0]  OVS_LAST      = 4'hF;   // 16 sample ticks per bit
  localparam logic [3:0]  HALF_LAST     = 4'h7;   // 8 ticks to mid start bit
  localparam logic [3:0]  M0_BIT_LAST   = 4'hB;   // core/12 per shift bit
  localparam logic [3:0]  M0_HALF_LAST  = 4'h5;
  localparam logic [15:0] M2_TICK_LAST  = 16'h0001; // core/32 bit rate
  localparam logic [7:0]  BREAK_TICKS   = 8'hA8;  // 10.5 bits of 16 ticks
  localparam logic [3:0]  LAST_BIT_8    = 4'h7;
  localparam logic [3:0]  LAST_BIT_9    = 4'h8;

  // transmit buffer shape
  localparam int TXQ_WIDTH = 9;
  localparam int TXQ_DEPTH = 8;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_SHIFT0} ucebd_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BREAK,
                            RX_SHIFT0} ucebd_rx_t;

  function automatic logic is_nine(input logic [1:0] m);
    return m[1];
  endfunction

endpackage

// ==== hw/ucebd_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module ucebd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
    logic                        ready;
  } ucebd_fifo_t;
  ucebd_fifo_t st;
  ucebd_fifo_t next_st;
  logic        push;
  logic        pop;

  always_comb begin
    next_st = st;
    push = in_valid && st.ready;
    pop = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wr_ptr] = in_data;
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    // registered so the port comes straight off a flop
    next_st.ready = (next_st.count != CW'(DEPTH));
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready  = st.ready;
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rd_ptr];
endmodule

////////////////////////////////////////////////////////////////////////////////

module ucebd_top
  import ucebd_pkg::*;
#(
  parameter int BAUD_BASE_CYC = 27
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       enhanced_uart_on,
  input  wire logic       ext_baud_tick,
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            txd,
  output logic            tx_fifo_ready
);
  typedef struct packed {
    logic [1:0]  mode;
    logic        sm2;
    logic        ren;
    logic        tb8;
    logic        rb8;
    logic        ti;
    logic        ri;
    logic [7:0]  rx_buf;
    logic        overrun_error;
    logic        fe;
    logic        be;
    logic [1:0]  sbth;
    logic [2:0]  div;
    logic [7:0]  rdata;
    logic [1:0]  rx_sync;
    logic        rx_prev;
    logic [15:0] brg_cnt;
    logic        tick;
    ucebd_tx_t   tx_state;
    logic [3:0]  tx_sub;
    logic [3:0]  tx_bit;
    logic [8:0]  tx_shift;
    logic        txd;
    logic        rxd_out;
    logic        rxd_oe;
    ucebd_rx_t   rx_state;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_shift;
    logic [7:0]  rx_elapsed;
    logic        rx_all_low;
  } ucebd_state_t;

  ucebd_state_t st;
  ucebd_state_t next_st;
  logic         q_in_valid;
  logic         q_in_ready;
  logic         q_out_valid;
  logic         q_pop;
  logic [8:0]   q_out_data;
  logic         line;
  logic         frame_end;
  logic         frame_stop;
  logic         frame_ninth;
  logic         frame_ok;
  logic [15:0]  brg_last;
  logic [3:0]   last_bit;

  // shift sum tops out at 10; large BAUD_BASE_CYC values overflow 16 bits
  function automatic logic [15:0] brg_limit(input logic [2:0] d, input logic [1:0] s);
    logic [4:0] sh;
    sh = {2'b00, d} + {3'b000, s};
    return (16'(BAUD_BASE_CYC) << sh) - 16'h0001;
  endfunction

  // tb8 sampled at write time so back-to-back frames keep their own ninth bit
  assign q_in_valid = sfr_wr && (sfr_addr == ADDR_SERIAL_DATA_BUFFER);

  ucebd_fifo #(
    .WIDTH (TXQ_WIDTH),
    .DEPTH (TXQ_DEPTH)
  ) ucebd_fifo_i (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   ({st.tb8, sfr_wdata}),
    .out_valid (q_out_valid),
    .out_ready (q_pop),
    .out_data  (q_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_st = st;
    q_pop = 1'b0;
    frame_end = 1'b0;
    frame_stop = 1'b0;
    frame_ninth = 1'b0;
    frame_ok = 1'b0;
    line = st.rx_sync[1];
    last_bit = is_nine(st.mode) ? LAST_BIT_9 : LAST_BIT_8;
    next_st.rx_sync = {st.rx_sync[0], rxd_in};
    next_st.rx_prev = st.rx_sync[1];

    // sample tick: 16 per bit in modes 1-3
    brg_last = (st.mode == MODE_9FIX) ? M2_TICK_LAST : brg_limit(st.div, st.sbth);
    if ((st.mode == MODE_9FIX) || enhanced_uart_on) begin
      next_st.brg_cnt = (st.brg_cnt >= brg_last) ? 16'h0000 : st.brg_cnt + 16'h0001;
      next_st.tick = (st.brg_cnt >= brg_last);
    end else begin
      next_st.brg_cnt = 16'h0000;
      next_st.tick = ext_baud_tick;
    end

    // software writes first so hardware sets below win
    if (sfr_wr && (sfr_addr == ADDR_SERIAL_CONTROL_REG)) begin
      next_st.mode = sfr_wdata[SC_MODE_HI:SC_MODE_LO];
      next_st.sm2 = sfr_wdata[SC_SM2];
      next_st.ren = sfr_wdata[SC_REN];
      next_st.tb8 = sfr_wdata[SC_TB8];
      next_st.rb8 = sfr_wdata[SC_RB8];
      next_st.ti = sfr_wdata[SC_TI];
      next_st.ri = sfr_wdata[SC_RI];
    end
    if (sfr_wr && (sfr_addr == ADDR_BAUD_ERROR_CONTROL_REG)) begin
      next_st.overrun_error = sfr_wdata[BE_OWE];
      next_st.sbth = sfr_wdata[BE_SBTH_HI:BE_SBTH_LO];
      next_st.div = sfr_wdata[BE_DIV_HI:BE_DIV_LO];
    end
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_SERIAL_CONTROL_REG:   next_st.rdata = {st.mode, st.sm2, st.ren, st.tb8, st.rb8, st.ti, st.ri};
        ADDR_SERIAL_DATA_BUFFER:   next_st.rdata = st.rx_buf;
        ADDR_BAUD_ERROR_CONTROL_REG: next_st.rdata = {st.overrun_error, st.fe, st.be, st.sbth, st.div};
        default:     next_st.rdata = 8'h00;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    unique case (st.tx_state)
      TX_IDLE: begin
        if (q_out_valid && (st.rx_state != RX_SHIFT0)) begin
          q_pop = 1'b1;
          next_st.tx_shift = q_out_data;
          next_st.tx_sub = 4'h0;
          next_st.tx_bit = 4'h0;
          next_st.txd = 1'b0;
          if (st.mode == MODE_SHIFT) begin
            next_st.tx_state = TX_SHIFT0;
            next_st.rxd_oe = 1'b1;
            next_st.rxd_out = q_out_data[0];
          end else begin
            next_st.tx_state = TX_START;
          end
        end
      end
      TX_START: begin
        if (st.tick) begin
          next_st.tx_sub = st.tx_sub + 4'h1;
          if (st.tx_sub == OVS_LAST) begin
            next_st.tx_state = TX_DATA;
            next_st.txd = st.tx_shift[0];
          end
        end
      end
      TX_DATA: begin
        if (st.tick) begin
          next_st.tx_sub = st.tx_sub + 4'h1;
          if (st.tx_sub == OVS_LAST) begin
            if (st.tx_bit == last_bit) begin
              next_st.tx_state = TX_STOP;
              next_st.txd = 1'b1;
              next_st.ti = 1'b1;
            end else begin
              next_st.tx_bit = st.tx_bit + 4'h1;
              next_st.tx_shift = {1'b0, st.tx_shift[8:1]};
              next_st.txd = st.tx_shift[1];
            end
          end
        end
      end
      TX_STOP: begin
        if (st.tick) begin
          next_st.tx_sub = st.tx_sub + 4'h1;
          if (st.tx_sub == OVS_LAST) begin
            next_st.tx_state = TX_IDLE;
          end
        end
      end
      TX_SHIFT0: begin
        next_st.tx_sub = st.tx_sub + 4'h1;
        if (st.tx_sub == M0_HALF_LAST) begin
          next_st.txd = 1'b1;
        end
        if (st.tx_sub == M0_BIT_LAST) begin
          next_st.tx_sub = 4'h0;
          if (st.tx_bit == LAST_BIT_8) begin
            next_st.tx_state = TX_IDLE;
            next_st.rxd_oe = 1'b0;
            next_st.ti = 1'b1;
          end else begin
            next_st.tx_bit = st.tx_bit + 4'h1;
            next_st.tx_shift = {1'b0, st.tx_shift[8:1]};
            next_st.rxd_out = st.tx_shift[1];
            next_st.txd = 1'b0;
          end
        end
      end
      default: next_st.tx_state = TX_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // receiver
    if (st.tick && (st.rx_state != RX_IDLE) && (st.rx_state != RX_SHIFT0)) begin
      next_st.rx_elapsed = (st.rx_elapsed == 8'hFF) ? 8'hFF : st.rx_elapsed + 8'h01;
      if (line) begin
        next_st.rx_all_low = 1'b0;
      end
    end
    unique case (st.rx_state)
      RX_IDLE: begin
        if (st.ren) begin
          if (st.mode == MODE_SHIFT) begin
            // shift-mode receive needs the flag clear and an idle transmitter
            if (!st.ri && (st.tx_state == TX_IDLE) && !q_out_valid) begin
              next_st.rx_state = RX_SHIFT0;
              next_st.rx_sub = 4'h0;
              next_st.rx_bit = 4'h0;
              next_st.txd = 1'b0;
            end
          end else if (st.rx_prev && !line) begin
            next_st.rx_state = RX_START;
            next_st.rx_sub = 4'h0;
            next_st.rx_elapsed = 8'h00;
            next_st.rx_all_low = 1'b1;
          end
        end
      end
      RX_START: begin
        if (st.tick) begin
          next_st.rx_sub = st.rx_sub + 4'h1;
          if (st.rx_sub == HALF_LAST) begin
            next_st.rx_sub = 4'h0;
            next_st.rx_bit = 4'h0;
            next_st.rx_state = line ? RX_IDLE : RX_DATA; // glitch rejected
          end
        end
      end
      RX_DATA: begin
        if (st.tick) begin
          next_st.rx_sub = st.rx_sub + 4'h1;
          if (st.rx_sub == OVS_LAST) begin
            next_st.rx_shift = {line, st.rx_shift[8:1]};
            next_st.rx_bit = st.rx_bit + 4'h1;
            if (st.rx_bit == last_bit) begin
              next_st.rx_state = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (st.tick) begin
          next_st.rx_sub = st.rx_sub + 4'h1;
          if (st.rx_sub == OVS_LAST) begin
            frame_end = 1'b1;
            frame_stop = line;
            frame_ninth = st.rx_shift[8];
            frame_ok = (enhanced_uart_on || !st.ri) &&
                       !(st.sm2 && (is_nine(st.mode) ? !frame_ninth : !frame_stop));
            if (frame_ok) begin
              next_st.rx_buf = is_nine(st.mode) ? st.rx_shift[7:0] : st.rx_shift[8:1];
              next_st.rb8 = is_nine(st.mode) ? frame_ninth : frame_stop;
              next_st.ri = 1'b1;
              if (st.ri) begin
                next_st.overrun_error = 1'b1;
              end
            end
            if (enhanced_uart_on) begin
              next_st.fe = !frame_stop;
              next_st.be = 1'b0;
            end
            next_st.rx_state = line ? RX_IDLE : RX_BREAK;
          end
        end
      end
      RX_BREAK: begin
        // frame already delivered; only the break length is still open
        if (st.tick) begin
          if (line) begin
            next_st.rx_state = RX_IDLE;
          end else if (enhanced_uart_on && st.rx_all_low &&
                       (st.rx_elapsed >= BREAK_TICKS)) begin
            next_st.be = 1'b1;
          end
        end
      end
      RX_SHIFT0: begin
        next_st.rx_sub = st.rx_sub + 4'h1;
        if (st.rx_sub == M0_HALF_LAST) begin
          next_st.txd = 1'b1;
          next_st.rx_shift = {line, st.rx_shift[8:1]};
        end
        if (st.rx_sub == M0_BIT_LAST) begin
          next_st.rx_sub = 4'h0;
          if (st.rx_bit == LAST_BIT_8) begin
            next_st.rx_state = RX_IDLE;
            next_st.rx_buf = st.rx_shift[8:1];
            next_st.ri = 1'b1;
          end else begin
            next_st.rx_bit = st.rx_bit + 4'h1;
            next_st.txd = 1'b0;
          end
        end
      end
      default: next_st.rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.txd <= 1'b1;
      st.rx_sync <= 2'b11;
      st.rx_prev <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata     = st.rdata;
  assign rxd_out       = st.rxd_out;
  assign rxd_oe        = st.rxd_oe;
  assign txd           = st.txd;
  assign tx_fifo_ready = q_in_ready;

  //////////////////////////////////////////////////////////////////////////////

  default clocking ucebd_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence ucebd_enter_stop;
    (st.tx_state == TX_DATA) ##1 (st.tx_state == TX_STOP);
  endsequence

  sequence ucebd_serial_data_buffer_write_idle;
    q_in_valid && q_in_ready && !q_out_valid && (st.tx_state == TX_IDLE) &&
      (st.rx_state == RX_IDLE);
  endsequence

  AST_ADDR_FILTER: assert property (
    frame_end && is_nine(st.mode) && st.sm2 && !frame_ninth && !st.ri |=> !st.ri)
    else $error("flag raised for filtered address frame");
  AST_NO_FILTER: assert property (
    frame_end && is_nine(st.mode) && !st.sm2 && (!st.ri || enhanced_uart_on) |=> st.ri)
    else $error("flag not raised for unfiltered frame");
  AST_RX_OFF: assert property (
    (st.rx_state == RX_IDLE) && !st.ren |=> (st.rx_state == RX_IDLE))
    else $error("reception started while disabled");
  AST_TI_AT_STOP: assert property (
    ucebd_enter_stop |-> st.ti && st.txd)
    else $error("transmit flag not set at stop bit");
  AST_RB8_STOP: assert property (
    frame_end && frame_ok && (st.mode == MODE_8VAR) |=> (st.rb8 == $past(frame_stop)))
    else $error("stop bit not latched in 8-bit mode");
  AST_OVERRUN: assert property (
    frame_end && frame_ok && st.ri |=> st.overrun_error && st.ri)
    else $error("overrun not flagged");
  AST_FRAME_ERR: assert property (
    frame_end && enhanced_uart_on |=> (st.fe == !$past(frame_stop)))
    else $error("framing fault not updated");
  AST_START_BIT: assert property (
    (st.tx_state == TX_START) |-> !st.txd ##0 (st.tx_state == TX_START)[*1])
    else $error("start bit not low");
  AST_TX_KICK: assert property (
    ucebd_serial_data_buffer_write_idle |-> ##[1:3] (st.tx_state != TX_IDLE))
    else $error("buffer write did not start transmitter");

endmodule

`default_nettype wire

// ==== test/ucebd_remote.sv ====
`timescale 1ns/10ps
`default_nettype none

// far-side serial partner: drives the receive line, samples the transmit line
module ucebd_remote (
  input  wire logic core_clk,
  input  wire logic txd,
  output logic      line_out
);
  initial line_out = 1'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // start 0, bits lsb first, then stop level; idle high afterwards
  task automatic send(input int nb, input logic [8:0] bits, input logic stop, input int cyc);
    @(posedge core_clk);
    #1 line_out = 1'h0;
    repeat (cyc) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      #1 line_out = bits[i];
      repeat (cyc) @(posedge core_clk);
    end
    #1 line_out = stop;
    repeat (cyc) @(posedge core_clk);
    #1 line_out = 1'h1;
  endtask

  // long low level, longer than any legal frame
  task automatic hold_low(input int cyc);
    @(posedge core_clk);
    #1 line_out = 1'h0;
    repeat (cyc) @(posedge core_clk);
    #1 line_out = 1'h1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // samples mid-bit; ok low means no start edge seen or start not low
  task automatic recv(input int nb, input int cyc, output logic [8:0] bits,
                      output logic stop, output logic ok);
    int n;
    bits = '0;
    stop = 1'h0;
    ok = 1'h0;
    n = 0;
    while (txd !== 1'h0 && n < 20000) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n < 20000) begin
      repeat (cyc / 2) @(posedge core_clk);
      ok = (txd === 1'h0);
      for (int i = 0; i < nb; i++) begin
        repeat (cyc) @(posedge core_clk);
        bits[i] = txd;
      end
      repeat (cyc) @(posedge core_clk);
      stop = txd;
    end
  endtask
endmodule

`default_nettype wire

// ==== test/uart_control_error_baud_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module uart_control_error_baud_tb;
  import ucebd_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic       b9;
    logic [7:0] data;
    logic [5:0] cyc;
    logic       nine;
    logic       exp_rdy;
    logic       exp_b9;
  } ucebd_rxrow_t;

  logic       core_clk = 1'h0;
  logic       rst_n = 1'h0;
  logic [7:0] sfr_addr = 8'h00;
  logic       sfr_wr = 1'h0;
  logic       sfr_rd = 1'h0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic       enhanced_uart_on = 1'h1;
  logic       ext_baud_tick = 1'h0;
  wire  logic rxd_in;
  logic       rxd_out;
  logic       rxd_oe;
  logic       txd;
  logic       tx_fifo_ready;
  logic       line;
  int         err_total = 0;
  int         n_checks = 0;

  // rxd pin: design drives it only in shift-register transmit
  assign rxd_in = rxd_oe ? rxd_out : line;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) ext_baud_tick <= ~ext_baud_tick;

  // base of 1 keeps the divide-by-128 case short
  ucebd_top #(.BAUD_BASE_CYC(1)) ucebd_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .enhanced_uart_on(enhanced_uart_on), .ext_baud_tick(ext_baud_tick),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
    .tx_fifo_ready(tx_fifo_ready)
  );

  ucebd_remote ucebd_remote_i (.core_clk(core_clk), .txd(txd), .line_out(line));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    @(posedge core_clk);
    #1 sfr_wr = 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 sfr_addr = a;
    sfr_rd = 1'h1;
    @(posedge core_clk);
    #1 sfr_rd = 1'h0;
    d = sfr_rdata;
  endtask

  // bounded wait for a txd level, returns cycles spent
  task automatic wait_txd(input logic lvl, output int n);
    n = 0;
    while (txd !== lvl) begin
      @(posedge core_clk);
      #1 n++;
      if (n > 20000) begin
        chk(16'h0001, 16'h0000, "txd wait timed out");
        report_and_stop();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  ucebd_rxrow_t rows [6] = '{
    '{8'h50, 1'h1, 8'hA5, 6'h10, 1'h0, 1'h1, 1'h1},
    '{8'h40, 1'h1, 8'h5A, 6'h10, 1'h0, 1'h0, 1'h0},
    '{8'h90, 1'h0, 8'h3C, 6'h20, 1'h1, 1'h1, 1'h0},
    '{8'hF0, 1'h0, 8'hC3, 6'h10, 1'h1, 1'h0, 1'h0},
    '{8'hF0, 1'h1, 8'h69, 6'h10, 1'h1, 1'h1, 1'h1},
    '{8'hD0, 1'h0, 8'h96, 6'h10, 1'h1, 1'h1, 1'h0}
  };
  logic [7:0] pre_codes [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                8'h18};

  initial begin
    logic [7:0] d;
    logic [7:0] last_rx;
    logic [8:0] bits;
    logic       stp;
    logic       ok;
    int         n;
    int         e;
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'h1;
    rd(ADDR_SERIAL_CONTROL_REG, d);
    chk(16'(d), 16'(SERIAL_CONTROL_REG_RST), "control reset");
    rd(ADDR_SERIAL_DATA_BUFFER, d);
    chk(16'(d), 16'(SERIAL_DATA_BUFFER_RST), "buffer reset");
    rd(ADDR_BAUD_ERROR_CONTROL_REG, d);
    chk(16'(d), 16'(BAUD_ERROR_CONTROL_REG_RST), "baud reset");
    rd(8'h97, d);
    chk(16'(d), 16'h0000, "unmapped read");
    chk(16'({txd, tx_fifo_ready}), 16'h0003, "idle pins");
    $display("test reset done");
    last_rx = 8'h00;
    // rows: receive filtering and flags
    foreach (rows[i]) begin
      wr(ADDR_SERIAL_CONTROL_REG, rows[i].ctrl);
      if (rows[i].nine) begin
        ucebd_remote_i.send(9, {rows[i].b9, rows[i].data}, 1'h1, int'(rows[i].cyc));
      end else begin
        ucebd_remote_i.send(8, {1'h0, rows[i].data}, rows[i].b9, int'(rows[i].cyc));
      end
      repeat (4) @(posedge core_clk);
      rd(ADDR_SERIAL_CONTROL_REG, d);
      chk(16'(d[SC_RI]), 16'(rows[i].exp_rdy), "rx ready");
      if (rows[i].exp_rdy) begin
        chk(16'(d[SC_RB8]), 16'(rows[i].exp_b9), "rx ninth");
        last_rx = rows[i].data;
      end
      rd(ADDR_SERIAL_DATA_BUFFER, d);
      chk(16'(d), 16'(last_rx), "rx buffer");
    end
    $display("test rx rows done");
    // transmit: 9-bit with ninth set, then 8-bit
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_SERIAL_CONTROL_REG, k == 0 ? 8'hC8 : 8'h40);
      wr(ADDR_SERIAL_DATA_BUFFER, k == 0 ? 8'h96 : 8'h3B);
      fork
        ucebd_remote_i.recv(k == 0 ? 9 : 8, 16, bits, stp, ok);
        begin
          rd(ADDR_SERIAL_CONTROL_REG, d);
          chk(16'(d[SC_TI]), 16'h0000, "tx done early");
        end
      join
      chk(16'({ok, stp}), 16'h0003, "tx start stop");
      chk(16'(bits), k == 0 ? 16'h0196 : 16'h003B, "tx bits");
      rd(ADDR_SERIAL_CONTROL_REG, d);
      chk(16'(d[SC_TI]), 16'h0001, "tx done");
      rd(ADDR_SERIAL_DATA_BUFFER, d);
      chk(16'(d), 16'(last_rx), "rx buffer separate");
      wait_txd(1'h1, n);
    end
    $display("test tx done");
    // prescale: a zero data bit lasts 16 ticks
    foreach (pre_codes[i]) begin
      wr(ADDR_BAUD_ERROR_CONTROL_REG, pre_codes[i]);
      wr(ADDR_SERIAL_CONTROL_REG, 8'h40);
      wr(ADDR_SERIAL_DATA_BUFFER, 8'h55);
      e = 16 << (pre_codes[i][4:3] + pre_codes[i][2:0]);
      wait_txd(1'h0, n);
      wait_txd(1'h1, n);
      wait_txd(1'h0, n);
      wait_txd(1'h1, n);
      chk(16'(n), 16'(e), "bit length");
      repeat (8 * e) @(posedge core_clk);
    end
    wr(ADDR_BAUD_ERROR_CONTROL_REG, 8'h00);
    $display("test prescale done");
    // overrun with enhanced on; dropped without it
    wr(ADDR_SERIAL_CONTROL_REG, 8'h50);
    ucebd_remote_i.send(8, 9'h011, 1'h1, 16);
    ucebd_remote_i.send(8, 9'h022, 1'h1, 16);
    repeat (4) @(posedge core_clk);
    rd(ADDR_BAUD_ERROR_CONTROL_REG, d);
    chk(16'(d[BE_OWE]), 16'h0001, "overrun");
    rd(ADDR_SERIAL_DATA_BUFFER, d);
    chk(16'(d), 16'h0022, "overrun data");
    wr(ADDR_BAUD_ERROR_CONTROL_REG, 8'h00);
    @(posedge core_clk);
    #1 enhanced_uart_on = 1'h0;
    wr(ADDR_SERIAL_CONTROL_REG, 8'h90);
    ucebd_remote_i.send(9, 9'h133, 1'h1, 32);
    ucebd_remote_i.send(9, 9'h144, 1'h1, 32);
    repeat (4) @(posedge core_clk);
    rd(ADDR_SERIAL_DATA_BUFFER, d);
    chk(16'(d), 16'h0033, "kept first");
    rd(ADDR_BAUD_ERROR_CONTROL_REG, d);
    chk(16'(d[BE_OWE]), 16'h0000, "no overrun");
    @(posedge core_clk);
    #1 enhanced_uart_on = 1'h1;
    $display("test overrun done");
    // framing fault, read-only error bits, break
    wr(ADDR_SERIAL_CONTROL_REG, 8'h50);
    ucebd_remote_i.send(8, 9'h00F, 1'h0, 16);
    repeat (4) @(posedge core_clk);
    wr(ADDR_BAUD_ERROR_CONTROL_REG, 8'h60);
    rd(ADDR_BAUD_ERROR_CONTROL_REG, d);
    chk(16'(d), 16'h0040, "frame fault held");
    wr(ADDR_SERIAL_CONTROL_REG, 8'h50);
    ucebd_remote_i.send(8, 9'h00F, 1'h1, 16);
    repeat (4) @(posedge core_clk);
    rd(ADDR_BAUD_ERROR_CONTROL_REG, d);
    chk(16'(d[BE_FE]), 16'h0000, "frame fault cleared");
    ucebd_remote_i.hold_low(16 * 14);
    repeat (8) @(posedge core_clk);
    rd(ADDR_BAUD_ERROR_CONTROL_REG, d);
    chk(16'(d[BE_FE:BE_BRK]), 16'h0003, "break");
    $display("test errors done");
    // shift-register transmit: data on rxd pin, taken at each clock rise
    wr(ADDR_SERIAL_CONTROL_REG, 8'h00);
    wr(ADDR_SERIAL_DATA_BUFFER, 8'hA5);
    bits = '0;
    for (int i = 0; i < 8; i++) begin
      wait_txd(1'h0, n);
      wait_txd(1'h1, n);
      bits[i] = rxd_out;
      chk(16'(rxd_oe), 16'h0001, "shift pin driven");
    end
    chk(16'(bits), 16'h00A5, "shift data");
    repeat (12) @(posedge core_clk);
    rd(ADDR_SERIAL_CONTROL_REG, d);
    chk(16'({d[SC_TI], rxd_oe}), 16'h0002, "shift done");
    $display("test shift done");
    report_and_stop();
  end
endmodule

`default_nettype wire
